/* File: rtmc_pkg.sv */
// Purpose: Shared constants for rigid tapping mode control
// Assumes: Lead words in 0.001 mm, thread counts in 0.01 per inch
// Notes: Alarm codes are decimal numbers carried as hex
package rtmc_pkg;
   localparam logic [3:0] RTMC_CTRL_OFS = 4'h0;
   localparam logic [3:0] RTMC_MAXSPD_OFS = 4'h4;
   localparam logic [3:0] RTMC_STAT_OFS = 4'h8;
   localparam int RTMC_CTRL_NOWAIT_BIT = 0;
   localparam int RTMC_CTRL_RETOVR_BIT = 1;
   localparam int RTMC_CTRL_CLR_BIT = 8;
   localparam int RTMC_STAT_RIGID_BIT = 3;
   localparam int RTMC_STAT_REFUSE_BIT = 4;
   localparam int RTMC_STAT_ALARM_BIT = 8;
   localparam int RTMC_STAT_CODE_POS = 16;
   localparam logic [15:0] RTMC_MAXSPD_RST = 16'h0BB8;
   localparam logic [8:0] RTMC_ALM_NONE = 9'h000;
   localparam logic [8:0] RTMC_ALM_LEAD = 9'h0C9;
   localparam logic [8:0] RTMC_ALM_NOF = 9'h0DA;
   localparam logic [8:0] RTMC_ALM_SZERO = 9'h0E6;
   localparam logic [8:0] RTMC_ALM_SMAX = 9'h0E7;
   localparam logic [8:0] RTMC_ALM_MOVE = 9'h0E8;
   localparam logic [8:0] RTMC_ALM_LADDER = 9'h0E9;
   localparam logic [8:0] RTMC_ALM_REPEAT = 9'h0EA;
   localparam logic [23:0] RTMC_LEAD_MIN = 24'h000001;
   localparam logic [23:0] RTMC_LEAD_MAX = 24'h07A120;
   localparam logic [23:0] RTMC_TPI_MIN = 24'h000006;
   localparam logic [23:0] RTMC_TPI_MAX = 24'h26C1E0;
   typedef enum logic [2:0] {
      RTMC_IDLE = 3'b000,
      RTMC_WAIT_POS = 3'b001,
      RTMC_WAIT_FIN = 3'b010,
      RTMC_RIGID = 3'b011,
      RTMC_CHECK = 3'b100,
      RTMC_TAPPING = 3'b101,
      RTMC_WAIT_DROP = 3'b110
   } rtmc_state_e;
endpackage

/* File: rtmc_top.sv */
// Purpose: Rigid tapping mode entry, checks, handshake and alarms
// Assumes: Block words decoded upstream; all inputs synchronous
// Notes: Registers over Avalon-MM, one wait cycle per access
`timescale 1ns/10ps
`default_nettype none
module rtmc_top
   import rtmc_pkg::*;
#(
   parameter int LEAD_W = 24,
   parameter int SPEED_W = 16,
   parameter int WORD_W = 16,
   parameter int HOLE_W = 8
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic blk_valid,
   output logic blk_ready,
   input wire logic blk_rigid_mode_select_code,
   input wire logic blk_tap_cycle,
   input wire logic blk_cycle_cancel,
   input wire logic blk_other_canned,
   input wire logic blk_group1_motion,
   input wire logic blk_axis_move,
   input wire logic blk_lead_present,
   input wire logic blk_lead_inch,
   input wire logic [LEAD_W-1:0] blk_lead,
   input wire logic blk_speed_present,
   input wire logic [SPEED_W-1:0] blk_speed,
   input wire logic blk_dwell_present,
   input wire logic [WORD_W-1:0] blk_dwell,
   input wire logic blk_peck_present,
   input wire logic [WORD_W-1:0] blk_peck,
   input wire logic blk_repeat_present,
   input wire logic [HOLE_W-1:0] blk_repeat,
   input wire logic controller_reset,
   input wire logic auto_operation,
   input wire logic manual_data_input_operation,
   input wire logic manual_feed,
   input wire logic dry_run,
   input wire logic machine_lock,
   input wire logic contour_speed_position_select,
   input wire logic ladder_rigid_mode_ack,
   input wire logic function_complete_ack,
   input wire logic spindle_pos_arrived,
   input wire logic spindle_turn_cmd,
   input wire logic spindle_turn_ccw,
   input wire logic tap_phase_retract,
   input wire logic hole_done,
   output logic spindle_dir_negative,
   output logic spindle_dir_positive,
   output logic rigid_tap_active_status,
   output logic spindle_pos_request,
   output logic contour_rigid,
   output logic manual_axis_inhibit,
   output logic motion_hold,
   output logic dry_feed_select,
   output logic override_enable,
   output logic hole_start,
   output logic dwell_enable,
   output logic [WORD_W-1:0] dwell_time,
   output logic peck_enable,
   output logic [WORD_W-1:0] peck_depth,
   output logic alarm_active,
   output logic [8:0] alarm_code
);
   if (LEAD_W < 22 || LEAD_W > 24 || SPEED_W > 16 || WORD_W < 1 || HOLE_W < 1)
   begin : g_bad
      $error("rtmc_top: unsupported widths");
   end

   function automatic logic in_range(input logic [23:0] v, input logic [23:0] lo, input logic [23:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   rtmc_state_e state;
   logic cancel_no_wait_bit;
   logic retract_override_en;
   logic [15:0] max_speed;
   logic mode_refused;
   logic await_first_tap;
   logic tap_pending;
   logic lead_present;
   logic lead_inch;
   logic [23:0] lead;
   logic [SPEED_W-1:0] speed;
   logic [HOLE_W-1:0] holes_left;
   logic take;
   logic mode_ok;
   logic cancel_hit;
   logic take_tap;
   logic bus_take;
   logic sw_clear;
   logic [8:0] next_alarm;
   logic next_refuse;

   assign take = blk_valid && blk_ready;
   assign mode_ok = (auto_operation || manual_data_input_operation) && !manual_feed;
   assign cancel_hit = blk_cycle_cancel || blk_other_canned || blk_group1_motion;
   assign take_tap = (take && blk_tap_cycle && !cancel_hit) || (state == RTMC_RIGID && tap_pending);
   assign bus_take = (avs_read || avs_write) && !avs_waitrequest;
   assign sw_clear = bus_take && avs_write && avs_address == RTMC_CTRL_OFS && avs_writedata[RTMC_CTRL_CLR_BIT];

   // Alarm and refusal sources
   always_comb
   begin
      next_alarm = RTMC_ALM_NONE;
      next_refuse = 1'b0;
      if (state == RTMC_CHECK)
      begin
         if (!lead_present)
            next_alarm = lead_inch ? RTMC_ALM_NOF : RTMC_ALM_LEAD;
         else if (!lead_inch && !in_range(lead, RTMC_LEAD_MIN, RTMC_LEAD_MAX))
            next_alarm = RTMC_ALM_LEAD;
         else if (lead_inch && !in_range(lead, RTMC_TPI_MIN, RTMC_TPI_MAX))
            next_alarm = RTMC_ALM_LEAD;
         else if (speed == '0)
            next_alarm = RTMC_ALM_SZERO;
         else if (16'(speed) > max_speed)
            next_alarm = RTMC_ALM_SMAX;
         else if (!ladder_rigid_mode_ack)
            next_alarm = RTMC_ALM_LADDER;
      end
      else if (state == RTMC_TAPPING && !ladder_rigid_mode_ack)
         next_alarm = RTMC_ALM_LADDER;
      else if (take && state == RTMC_RIGID && !cancel_hit)
      begin
         if (blk_rigid_mode_select_code)
            next_alarm = RTMC_ALM_REPEAT;
         else if (blk_axis_move && !blk_tap_cycle && await_first_tap)
            next_alarm = RTMC_ALM_MOVE;
         else if (blk_tap_cycle && !mode_ok)
            next_refuse = 1'b1;
      end
      else if (take && state == RTMC_IDLE && blk_rigid_mode_select_code && !mode_ok)
         next_refuse = 1'b1;
   end

   // Mode sequencing
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state <= RTMC_IDLE;
         blk_ready <= 1'b0;
         rigid_tap_active_status <= 1'b0;
         spindle_pos_request <= 1'b0;
         await_first_tap <= 1'b0;
         tap_pending <= 1'b0;
      end
      else if (controller_reset)
      begin
         state <= RTMC_IDLE;
         blk_ready <= 1'b0;
         rigid_tap_active_status <= 1'b0;
         spindle_pos_request <= 1'b0;
         await_first_tap <= 1'b0;
         tap_pending <= 1'b0;
      end
      else
      begin
         blk_ready <= !take && (state == RTMC_IDLE || state == RTMC_RIGID) && !tap_pending;
         case (state)
            RTMC_IDLE:
               if (take && blk_rigid_mode_select_code && mode_ok)
               begin
                  state <= RTMC_WAIT_POS;
                  spindle_pos_request <= 1'b1;
                  tap_pending <= blk_tap_cycle;
               end
            RTMC_WAIT_POS:
               if (spindle_pos_arrived)
               begin
                  state <= RTMC_WAIT_FIN;
                  rigid_tap_active_status <= 1'b1;
                  await_first_tap <= 1'b1;
               end
            RTMC_WAIT_FIN:
               if (function_complete_ack)
                  state <= RTMC_RIGID;
            RTMC_RIGID:
               if (take && cancel_hit)
               begin
                  rigid_tap_active_status <= 1'b0;
                  spindle_pos_request <= 1'b0;
                  await_first_tap <= 1'b0;
                  state <= cancel_no_wait_bit ? RTMC_IDLE : RTMC_WAIT_DROP;
               end
               else if (take_tap && next_alarm == RTMC_ALM_NONE && !next_refuse)
               begin
                  state <= RTMC_CHECK;
                  tap_pending <= 1'b0;
                  await_first_tap <= 1'b0;
               end
            RTMC_CHECK:
               state <= (next_alarm == RTMC_ALM_NONE) ? RTMC_TAPPING : RTMC_RIGID;
            RTMC_TAPPING:
               if (next_alarm != RTMC_ALM_NONE || (hole_done && holes_left <= HOLE_W'(1)))
                  state <= RTMC_RIGID;
            RTMC_WAIT_DROP:
               if (!ladder_rigid_mode_ack)
                  state <= RTMC_IDLE;
            default:
               state <= RTMC_IDLE;
         endcase
      end
   end

   // Modal words and hole counting
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lead_present <= 1'b0;
         lead_inch <= 1'b0;
         lead <= '0;
         speed <= '0;
         dwell_time <= '0;
         peck_depth <= '0;
         holes_left <= '0;
         hole_start <= 1'b0;
      end
      else
      begin
         hole_start <= 1'b0;
         if (take && blk_speed_present)
            speed <= blk_speed;
         // Lead, dwell, peck and repeat words kept only from tapping blocks
         if (take && blk_tap_cycle && !cancel_hit)
         begin
            lead_present <= blk_lead_present;
            lead_inch <= blk_lead_inch;
            lead <= 24'(blk_lead);
            dwell_time <= blk_dwell_present ? blk_dwell : '0;
            peck_depth <= blk_peck_present ? blk_peck : '0;
            // Absent or zero count is one hole
            holes_left <= (blk_repeat_present && blk_repeat != '0) ? blk_repeat : HOLE_W'(1);
         end
         if (state == RTMC_CHECK && next_alarm == RTMC_ALM_NONE)
            hole_start <= 1'b1;
         if (state == RTMC_TAPPING && hole_done && holes_left > HOLE_W'(1) && next_alarm == RTMC_ALM_NONE)
         begin
            holes_left <= holes_left - HOLE_W'(1);
            hole_start <= 1'b1;
         end
      end
   end

   // Alarm latch; a new event beats a software clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         alarm_active <= 1'b0;
         alarm_code <= RTMC_ALM_NONE;
         mode_refused <= 1'b0;
      end
      else
      begin
         if (next_alarm != RTMC_ALM_NONE)
         begin
            alarm_active <= 1'b1;
            alarm_code <= next_alarm;
         end
         else if (sw_clear || controller_reset)
         begin
            alarm_active <= 1'b0;
            alarm_code <= RTMC_ALM_NONE;
         end
         if (next_refuse)
            mode_refused <= 1'b1;
         else if (sw_clear)
            mode_refused <= 1'b0;
      end
   end

   // Machine-facing outputs
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         spindle_dir_negative <= 1'b0;
         spindle_dir_positive <= 1'b0;
         contour_rigid <= 1'b0;
         manual_axis_inhibit <= 1'b0;
         motion_hold <= 1'b0;
         dry_feed_select <= 1'b0;
         override_enable <= 1'b0;
         dwell_enable <= 1'b0;
         peck_enable <= 1'b0;
      end
      else
      begin
         // Direction only while turning in mode
         // Interlock and lock do not stop it
         spindle_dir_negative <= rigid_tap_active_status && spindle_turn_cmd && !spindle_turn_ccw;
         spindle_dir_positive <= rigid_tap_active_status && spindle_turn_cmd && spindle_turn_ccw;
         contour_rigid <= rigid_tap_active_status || contour_speed_position_select;
         manual_axis_inhibit <= rigid_tap_active_status;
         motion_hold <= machine_lock && state == RTMC_TAPPING;
         // Dry run feed along tapping axis
         dry_feed_select <= dry_run && state == RTMC_TAPPING;
         // Override only on retract if enabled
         override_enable <= state == RTMC_TAPPING && tap_phase_retract && retract_override_en && !dry_run;
         dwell_enable <= dwell_time != '0;
         peck_enable <= peck_depth != '0;
      end
   end

   // Avalon slave: request seen, then one cycle with waitrequest low
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
         cancel_no_wait_bit <= 1'b0;
         retract_override_en <= 1'b0;
         max_speed <= RTMC_MAXSPD_RST;
      end
      else
      begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest)
         begin
            if (avs_address == RTMC_CTRL_OFS)
               avs_readdata <= {30'h0, retract_override_en, cancel_no_wait_bit};
            else if (avs_address == RTMC_MAXSPD_OFS)
               avs_readdata <= {16'h0, max_speed};
            else if (avs_address == RTMC_STAT_OFS)
               avs_readdata <= {7'h0, alarm_code, 7'h0, alarm_active, 3'h0, mode_refused,
                                rigid_tap_active_status, state};
            else
               avs_readdata <= '0;
         end
         if (bus_take && avs_write)
         begin
            if (avs_address == RTMC_CTRL_OFS)
            begin
               cancel_no_wait_bit <= avs_writedata[RTMC_CTRL_NOWAIT_BIT];
               retract_override_en <= avs_writedata[RTMC_CTRL_RETOVR_BIT];
            end
            else if (avs_address == RTMC_MAXSPD_OFS)
               max_speed <= avs_writedata[15:0];
         end
      end
   end

   sequence s_select_taken;
      state == RTMC_IDLE && take && blk_rigid_mode_select_code && mode_ok && !controller_reset;
   endsequence
   sequence s_cancel_taken;
      state == RTMC_RIGID && take && cancel_hit && !controller_reset;
   endsequence

   // Enable is registered from the previous dwell word
   a_dwell_zero_skip: assert property (@(posedge clock) disable iff (rst)
      dwell_enable |-> $past(dwell_time) != '0)
      else $error("dwell enabled with zero time");
   a_hole_repeat_next: assert property (@(posedge clock) disable iff (rst)
      state == RTMC_TAPPING && hole_done && holes_left > HOLE_W'(1) && ladder_rigid_mode_ack && !controller_reset
      |=> hole_start && state == RTMC_TAPPING)
      else $error("next hole not started");
   a_lead_missing_alarm: assert property (@(posedge clock) disable iff (rst)
      state == RTMC_CHECK && !lead_present && !lead_inch |=> alarm_code == RTMC_ALM_LEAD)
      else $error("missing lead without alarm");
   a_speed_max_alarm: assert property (@(posedge clock) disable iff (rst)
      state == RTMC_CHECK && lead_present && !lead_inch && in_range(lead, RTMC_LEAD_MIN, RTMC_LEAD_MAX)
      && 16'(speed) > max_speed && !controller_reset
      |=> alarm_active && alarm_code == RTMC_ALM_SMAX && state == RTMC_RIGID)
      else $error("overspeed not alarmed");
   a_infeed_no_override: assert property (@(posedge clock) disable iff (rst)
      override_enable |-> $past(tap_phase_retract) && !$past(dry_run))
      else $error("override outside retract");
   a_lock_holds_axis: assert property (@(posedge clock) disable iff (rst)
      machine_lock && state == RTMC_TAPPING |=> motion_hold)
      else $error("machine lock not holding");
   a_select_pos_request: assert property (@(posedge clock) disable iff (rst)
      s_select_taken |=> spindle_pos_request && state == RTMC_WAIT_POS)
      else $error("position mode not requested");
   a_cancel_drops_status: assert property (@(posedge clock) disable iff (rst)
      s_cancel_taken ##1 !controller_reset |-> !rigid_tap_active_status ##0
      (state == (cancel_no_wait_bit ? RTMC_IDLE : RTMC_WAIT_DROP)))
      else $error("cancel did not drop status");
   a_dir_exclusive: assert property (@(posedge clock) disable iff (rst)
      !(spindle_dir_negative && spindle_dir_positive))
      else $error("both direction outputs high");
   a_status_in_mode: assert property (@(posedge clock) disable iff (rst)
      state == RTMC_TAPPING |-> rigid_tap_active_status && !blk_ready)
      else $error("status low while tapping");
endmodule
`default_nettype wire

/* File: rtmc_ladder_model.sv */
// Purpose: Ladder controller model for the rigid tapping handshake
// Assumes: dly sets spindle arrival and mode drop latency
// Notes: fault pulls the mode input low while the device is in mode
`timescale 1ns/10ps
`default_nettype none
module rtmc_ladder_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic spindle_pos_request,
   input wire logic rigid_tap_active_status,
   input wire logic [3:0] dly,
   input wire logic fault,
   output logic spindle_pos_arrived,
   output logic function_complete_ack,
   output logic ladder_rigid_mode_ack
);
   logic [3:0] pc;
   logic [3:0] dc;
   // Slow spindle exposes a device that skips the wait
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pc <= 4'h0;
         spindle_pos_arrived <= 1'h0;
      end
      else if (!spindle_pos_request)
      begin
         pc <= 4'h0;
         spindle_pos_arrived <= 1'h0;
      end
      else if (pc == dly)
         spindle_pos_arrived <= 1'h1;
      else
         pc <= pc + 4'h1;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         function_complete_ack <= 1'h0;
      else
         function_complete_ack <= rigid_tap_active_status;
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ladder_rigid_mode_ack <= 1'h0;
         dc <= 4'h0;
      end
      else if (rigid_tap_active_status && !fault)
      begin
         ladder_rigid_mode_ack <= 1'h1;
         dc <= 4'h0;
      end
      else if (dc == dly)
         ladder_rigid_mode_ack <= 1'h0;
      else
         dc <= dc + 4'h1;
   end
endmodule
`default_nettype wire

/* File: tb_rigid_tapping_mode_control.sv */
// Purpose: Self-checking bench for rigid tapping mode control
// Assumes: Alarms stand until cleared through the control register or by controller_reset
// Notes: Mode drop latency is set by the bench to expose the wait
`timescale 1ns/10ps
`default_nettype none
module tb_rigid_tapping_mode_control
   import rtmc_pkg::*;
;
   localparam logic [5:0] SEL = 6'h01, TAP = 6'h12, CAN = 6'h04;
   localparam logic [5:0] AK [9] = '{6'h08, 6'h02, 6'h12, 6'h12, 6'h22, 6'h32, 6'h12, 6'h12, 6'h01};
   localparam logic [23:0] AL [9] = '{24'h0, 24'h0, 24'h0, 24'h07A121, 24'h0, 24'h000005, 24'h0007D0,
      24'h0007D0, 24'h0};
   localparam logic [15:0] AS [9] = '{16'h00C8, 16'h00C8, 16'h00C8, 16'h00C8, 16'h00C8, 16'h00C8, 16'h0000,
      16'h0BB9, 16'h00C8};
   localparam logic [8:0] AC [9] = '{RTMC_ALM_MOVE, RTMC_ALM_LEAD, RTMC_ALM_LEAD, RTMC_ALM_LEAD, RTMC_ALM_NOF,
      RTMC_ALM_LEAD, RTMC_ALM_SZERO, RTMC_ALM_SMAX, RTMC_ALM_REPEAT};
   logic clock = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0, blk_valid = 1'h0, fault = 1'h0;
   logic [3:0] avs_address = 4'h0, dly = 4'h2;
   logic [31:0] avs_writedata = 32'h0, ctrl = 32'h0, rd, avs_readdata;
   logic [5:0] k = 6'h0;
   logic [23:0] blk_lead = 24'h0;
   logic [15:0] blk_speed = 16'h0, blk_dwell = 16'h0, blk_peck = 16'h0, dwell_time, peck_depth;
   logic [7:0] blk_repeat = 8'h0;
   logic blk_speed_present = 1'h1, blk_dwell_present = 1'h0, blk_peck_present = 1'h0, blk_repeat_present = 1'h0;
   logic controller_reset = 1'h0, auto_operation = 1'h1, manual_data_input_operation = 1'h0, manual_feed = 1'h0;
   logic dry_run = 1'h0, machine_lock = 1'h0, contour_speed_position_select = 1'h0, hole_done = 1'h0;
   logic spindle_turn_cmd = 1'h0, spindle_turn_ccw = 1'h0, tap_phase_retract = 1'h0;
   logic [1:0] cx = 2'h0;
   logic avs_waitrequest, blk_ready, spindle_pos_arrived, function_complete_ack, ladder_rigid_mode_ack;
   logic spindle_dir_negative, spindle_dir_positive, rigid_tap_active_status, spindle_pos_request, contour_rigid;
   logic manual_axis_inhibit, motion_hold, dry_feed_select, override_enable, hole_start, dwell_enable;
   logic peck_enable, alarm_active;
   logic [8:0] alarm_code;
   logic [5:0] obs;
   int err_total = 0, n_tests = 0, n_hole = 0;
   assign obs = {ladder_rigid_mode_ack, spindle_pos_request, alarm_active, hole_start, rigid_tap_active_status,
      blk_ready};
   rtmc_top dut (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .blk_valid, .blk_ready, .blk_rigid_mode_select_code(k[0]), .blk_tap_cycle(k[1]),
      .blk_cycle_cancel(k[2]), .blk_other_canned(cx[0]), .blk_group1_motion(cx[1]), .blk_axis_move(k[3]),
      .blk_lead_present(k[4]), .blk_lead_inch(k[5]), .blk_lead, .blk_speed_present, .blk_speed,
      .blk_dwell_present, .blk_dwell, .blk_peck_present, .blk_peck, .blk_repeat_present, .blk_repeat,
      .controller_reset, .auto_operation, .manual_data_input_operation, .manual_feed, .dry_run, .machine_lock,
      .contour_speed_position_select, .ladder_rigid_mode_ack, .function_complete_ack, .spindle_pos_arrived,
      .spindle_turn_cmd, .spindle_turn_ccw, .tap_phase_retract, .hole_done, .spindle_dir_negative,
      .spindle_dir_positive, .rigid_tap_active_status, .spindle_pos_request, .contour_rigid,
      .manual_axis_inhibit, .motion_hold, .dry_feed_select, .override_enable, .hole_start, .dwell_enable,
      .dwell_time, .peck_enable, .peck_depth, .alarm_active, .alarm_code);
   rtmc_ladder_model ladder (.clock, .rst, .spindle_pos_request, .rigid_tap_active_status, .dly, .fault,
      .spindle_pos_arrived, .function_complete_ack, .ladder_rigid_mode_ack);
   always #4 clock = ~clock;
   always @(posedge clock)
      if (hole_start === 1'h1)
         n_hole++;
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(inout int c);
      @(posedge clock);
      c++;
      if (c > 300)
      begin
         check("wait bound", 32'h1, 32'h0);
         print_verdict();
      end
   endtask
   task automatic wt(input int i, input logic v);
      int c;
      c = 0;
      while (obs[i] !== v)
         tick(c);
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do
         tick(c);
      while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask
   task automatic blk(input logic [5:0] kk, input logic [23:0] ld, input logic [15:0] sp);
      int c;
      c = 0;
      @(posedge clock);
      k <= kk;
      blk_lead <= ld;
      blk_speed <= sp;
      blk_valid <= 1'h1;
      do
         tick(c);
      while (blk_ready !== 1'h1);
      blk_valid <= 1'h0;
   endtask
   task automatic clr();
      bus(1'h1, RTMC_CTRL_OFS, ctrl | 32'h100);
      @(posedge clock);
      check("alarm_clear", alarm_active, 1'h0);
   endtask
   task automatic t_reset();
      check("status", rigid_tap_active_status, 1'h0);
      check("dirs", {spindle_dir_negative, spindle_dir_positive}, 2'h0);
      bus(1'h0, RTMC_MAXSPD_OFS, 32'h0);
      check("maxspd", rd, {16'h0, RTMC_MAXSPD_RST});
      bus(1'h0, 4'hC, 32'h0);
      check("unmapped", rd, 32'h0);
   endtask
   task automatic t_refuse();
      manual_feed <= 1'h1;
      blk(SEL, 24'h0, 16'h00C8);
      bus(1'h0, RTMC_STAT_OFS, 32'h0);
      check("refused", rd[RTMC_STAT_REFUSE_BIT], 1'h1);
      check("status", rigid_tap_active_status, 1'h0);
      manual_feed <= 1'h0;
      clr();
   endtask
   task automatic t_enter();
      contour_speed_position_select <= 1'h0;
      auto_operation <= 1'h0;
      manual_data_input_operation <= 1'h1;
      wt(5, 1'h0);
      blk(SEL, 24'h0, 16'h00C8);
      wt(4, 1'h1);
      check("early_status", rigid_tap_active_status, 1'h0);
      wt(1, 1'h1);
      wt(0, 1'h1);
      check("contour", contour_rigid, 1'h1);
      check("inhibit", manual_axis_inhibit, 1'h1);
   endtask
   task automatic t_alarms();
      for (int i = 0; i < 9; i++)
      begin
         blk(AK[i], AL[i], AS[i]);
         wt(3, 1'h1);
         check("alarm_code", alarm_code, AC[i]);
         clr();
      end
   endtask
   task automatic t_tap();
      ctrl = 32'h2;
      bus(1'h1, RTMC_CTRL_OFS, ctrl);
      blk_dwell_present <= 1'h1;
      blk_peck_present <= 1'h1;
      blk_peck <= 16'h0005;
      blk_repeat_present <= 1'h1;
      blk_repeat <= 8'h03;
      machine_lock <= 1'h1;
      dry_run <= 1'h1;
      spindle_turn_cmd <= 1'h1;
      n_hole = 0;
      blk(TAP, 24'h0007D0, 16'h00C8);
      wt(2, 1'h1);
      @(posedge clock);
      check("dir_neg", {spindle_dir_negative, spindle_dir_positive}, 2'h2);
      check("hold", motion_hold, 1'h1);
      check("dry", {dry_feed_select, override_enable}, 2'h2);
      check("dwell", dwell_enable, 1'h0);
      check("peck", {peck_enable, peck_depth}, 17'h10005);
      spindle_turn_ccw <= 1'h1;
      repeat (2) @(posedge clock);
      check("dir_pos", {spindle_dir_negative, spindle_dir_positive}, 2'h1);
      spindle_turn_cmd <= 1'h0;
      repeat (2) @(posedge clock);
      check("dir_stop", {spindle_dir_negative, spindle_dir_positive}, 2'h0);
      tap_phase_retract <= 1'h1;
      repeat (2) @(posedge clock);
      check("ovr_dry", override_enable, 1'h0);
      dry_run <= 1'h0;
      repeat (2) @(posedge clock);
      check("ovr_retract", override_enable, 1'h1);
      tap_phase_retract <= 1'h0;
      repeat (2) @(posedge clock);
      check("ovr_infeed", override_enable, 1'h0);
      for (int h = 0; h < 3; h++)
      begin
         @(posedge clock);
         hole_done <= 1'h1;
         @(posedge clock);
         hole_done <= 1'h0;
         if (h < 2)
            wt(2, 1'h1);
      end
      wt(0, 1'h1);
      check("holes", n_hole, 32'h3);
      machine_lock <= 1'h0;
      dry_run <= 1'h0;
   endtask
   task automatic t_ladder();
      fault <= 1'h1;
      blk_dwell <= 16'h07D0;
      wt(5, 1'h0);
      blk(TAP, 24'h0007D0, 16'h00C8);
      wt(3, 1'h1);
      check("alarm_code", alarm_code, RTMC_ALM_LADDER);
      check("dwell_on", {dwell_enable, dwell_time}, 17'h107D0);
      fault <= 1'h0;
      clr();
   endtask
   task automatic t_cancel(input logic nw, input logic [1:0] src);
      ctrl = {31'h0, nw};
      bus(1'h1, RTMC_CTRL_OFS, ctrl);
      dly <= 4'h8;
      cx <= src;
      blk_dwell <= 16'h0000;
      blk((src == 2'h0) ? CAN : 6'h00, 24'h0, 16'h00C8);
      cx <= 2'h0;
      wt(1, 1'h0);
      wt(0, 1'h1);
      check("mode_ack", ladder_rigid_mode_ack, nw);
      check("dwell_kept", dwell_time, 16'h07D0);
      dly <= 4'h2;
      t_enter();
   endtask
   task automatic t_creset();
      @(posedge clock);
      controller_reset <= 1'h1;
      @(posedge clock);
      controller_reset <= 1'h0;
      // Outputs lag the status flop by one cycle
      repeat (2) @(posedge clock);
      check("status", {rigid_tap_active_status, contour_rigid}, 2'h0);
      check("pos_req", {manual_axis_inhibit, spindle_pos_request}, 2'h0);
   endtask
   initial
   begin
      repeat (4) @(posedge clock);
      rst <= 1'h0;
      t_reset();
      t_refuse();
      t_enter();
      t_alarms();
      t_tap();
      t_ladder();
      t_cancel(1'h0, 2'h0);
      t_cancel(1'h1, 2'h1);
      t_cancel(1'h0, 2'h2);
      t_creset();
      print_verdict();
   end
endmodule
`default_nettype wire
